// >>> hw/nfc_defines.svh
// Purpose: constants of the flash bus controller
// Assumes: 20 MHz core clock, 50 ns period
// Notes:   times in ns, cycle counts derived and rounded up as least times
`ifndef NFC_DEFINES_SVH
`define NFC_DEFINES_SVH

`define NFC_CLK_NS        50
`define NFC_T_WP_NS       25
`define NFC_T_WH_NS       15
`define NFC_T_RP_NS       25
`define NFC_T_REH_NS      15
`define NFC_T_REA_NS      30
`define NFC_CYC(ns)       (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_WP_CYC        `NFC_CYC(`NFC_T_WP_NS)
`define NFC_WH_CYC        `NFC_CYC(`NFC_T_WH_NS)
// read strobe stays low for access time plus both synchroniser stages,
// so the word sampled at its end is the one launched at its fall
`define NFC_RP_CYC        (`NFC_CYC(`NFC_T_REA_NS) + 2)
`define NFC_REH_CYC       `NFC_CYC(`NFC_T_REH_NS)

// register offsets of the controller's own port
`define NFC_REG_CMD       4'h0
`define NFC_REG_ADDR      4'h1
`define NFC_REG_DATA      4'h2
`define NFC_REG_CTRL      4'h3
`define NFC_REG_STAT      4'h4
`define NFC_REG_COL       4'h5

// command register fields
`define NFC_CMD_CMD       3'h0
`define NFC_CMD_ADDR      3'h1
`define NFC_CMD_WDATA     3'h2
`define NFC_CMD_RDATA     3'h3

// control bits
`define NFC_CTRL_CE       0
`define NFC_CTRL_WG       1
`define NFC_CTRL_LOCK     2
`define NFC_CTRL_X16      3
`define NFC_CTRL_RST      16'h0002

// read commands selecting the page half, and the erase command
`define NFC_OP_READ_LO    8'h00
`define NFC_OP_READ_HI    8'h01
`define NFC_OP_ERASE      8'h60

`endif

// >>> hw/nfc_pkg.sv
// Purpose: types of the flash bus controller
// Assumes: nfc_defines.svh holds the numbers
// Notes:   none
package nfc_pkg;
  typedef enum logic [1:0] {NFC_K_CMD, NFC_K_ADDR, NFC_K_WDATA, NFC_K_RDATA} nfc_kind_e;
  typedef struct packed {
    logic        cle;
    logic        ale;
    logic        ce_n;
    logic        we_n;
    logic        re_n;
    logic        wg_n;
    logic        lock_sel;
    logic        io_oe;
    logic [15:0] io_out;
  } nfc_pins_s;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } nfc_bus_s;
endpackage

// >>> hw/nfc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk_i
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module nfc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      // reset to the pin's idle level so no false event follows reset
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
    end
    else if (ce_i)
    begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
    end
  end
  assign q_o = s2_reg;
endmodule

// >>> hw/nfc_host.sv
// Purpose: host controller driving the pins of a NAND flash device
// Assumes: device pins on I/O, strobes, enables; software on a plain register port
// Notes:   one bus cycle per CMD register write taken in idle, none for a rejected 01h; status shows busy, address count, reject and half
`timescale 1ns/100ps
`include "nfc_defines.svh"
module nfc_host (
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                clk_en_i,
  input  wire nfc_pkg::nfc_bus_s   bus_i,
  output logic              [15:0] rdata_o,
  output nfc_pkg::nfc_pins_s       pins_o,
  input  wire logic         [15:0] io_in_i,
  input  wire logic                busy_n_i
);
  import nfc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {S_IDLE, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH} nfc_state_e;
  nfc_state_e  st_reg, st_next;
  logic [3:0]  cnt_reg, cnt_next;
  nfc_kind_e   kind_reg, kind_next;
  logic [15:0] out_reg, out_next;
  logic [15:0] rd_reg, rd_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] col_reg, col_next;
  logic [1:0]  acyc_reg, acyc_next;
  logic        half_reg, half_next;
  logic        rej_reg, rej_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [16:0] sync_q;
  wire logic   busy_n_s = sync_q[16];
  wire logic [15:0] io_s = sync_q[15:0];

  nfc_sync #(.W(17), .RST_VAL({1'b1, 16'h0000})) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (clk_en_i),
    .d_i        ({busy_n_i, io_in_i}),
    .q_o        (sync_q)
  );

  function automatic logic [15:0] rd_mux(input logic [3:0] a, input logic [15:0] st);
    unique case (a)
      `NFC_REG_CTRL: rd_mux = ctrl_reg;
      `NFC_REG_DATA: rd_mux = rd_reg;
      `NFC_REG_STAT: rd_mux = st;
      `NFC_REG_COL:  rd_mux = col_reg;
      default:       rd_mux = 16'h0000;
    endcase
  endfunction

  wire logic x16 = ctrl_reg[`NFC_CTRL_X16];
  wire logic idle = (st_reg == S_IDLE);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    kind_next  = kind_reg;
    out_next   = out_reg;
    rd_next    = rd_reg;
    ctrl_next  = ctrl_reg;
    col_next   = col_reg;
    acyc_next  = acyc_reg;
    half_next  = half_reg;
    rej_next   = rej_reg;
    rdata_next = bus_i.rd ? rd_mux(bus_i.addr,
                 {10'h000, half_reg, rej_reg, acyc_reg, ~busy_n_s, ~idle}) : 16'h0000;
    if (bus_i.wr && bus_i.addr == `NFC_REG_CTRL)
      ctrl_next = bus_i.wdata;
    if (bus_i.wr && bus_i.addr == `NFC_REG_DATA)
      out_next = bus_i.wdata;
    unique case (st_reg)
      S_IDLE:
      begin
        if (bus_i.wr && bus_i.addr == `NFC_REG_CMD)
        begin
          kind_next = nfc_kind_e'(bus_i.wdata[9:8]);
          rej_next  = 1'b0;
          if (bus_i.wdata[9:8] != 2'(`NFC_CMD_WDATA))
            out_next = {8'h00, bus_i.wdata[7:0]};
          if (bus_i.wdata[9:8] == 2'(`NFC_CMD_CMD) && x16
              && bus_i.wdata[7:0] == `NFC_OP_READ_HI)
            rej_next = 1'b1;
          else if (bus_i.wdata[9:8] == 2'(`NFC_CMD_RDATA))
          begin
            st_next  = S_RLOW;
            cnt_next = 4'(`NFC_RP_CYC);
          end
          else
          begin
            st_next  = S_WLOW;
            cnt_next = 4'(`NFC_WP_CYC);
          end
          // track half and address cycle count
          if (bus_i.wdata[9:8] == 2'(`NFC_CMD_CMD))
          begin
            acyc_next = 2'h0;
            if (bus_i.wdata[7:0] == `NFC_OP_READ_LO)
              half_next = 1'b0;
            else if (bus_i.wdata[7:0] == `NFC_OP_READ_HI && !x16)
              half_next = 1'b1;
          end
          else if (bus_i.wdata[9:8] == 2'(`NFC_CMD_ADDR) && acyc_reg != 2'h3)
            acyc_next = acyc_reg + 2'h1;
        end
      end
      S_WLOW:
        if (cnt_reg <= 4'h1)
        begin
          st_next  = S_WHIGH;
          cnt_next = 4'(`NFC_WH_CYC);
        end
        else
          cnt_next = cnt_reg - 4'h1;
      S_WHIGH:
        if (cnt_reg <= 4'h1)
          st_next = S_IDLE;
        else
          cnt_next = cnt_reg - 4'h1;
      S_RLOW:
        // capture at end of low phase
        if (cnt_reg <= 4'h1)
        begin
          rd_next  = x16 ? io_s : {8'h00, io_s[7:0]};
          col_next = col_reg + 16'h0001;
          st_next  = S_RHIGH;
          cnt_next = 4'(`NFC_REH_CYC);
        end
        else
          cnt_next = cnt_reg - 4'h1;
      S_RHIGH:
        if (cnt_reg <= 4'h1)
          st_next = S_IDLE;
        else
          cnt_next = cnt_reg - 4'h1;
    endcase
    if (bus_i.wr && bus_i.addr == `NFC_REG_COL)
      col_next = bus_i.wdata;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_reg    <= S_IDLE;
      cnt_reg   <= 4'h0;
      kind_reg  <= NFC_K_CMD;
      out_reg   <= 16'h0000;
      rd_reg    <= 16'h0000;
      ctrl_reg  <= `NFC_CTRL_RST;
      col_reg   <= 16'h0000;
      acyc_reg  <= 2'h0;
      half_reg  <= 1'b0;
      rej_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else if (clk_en_i)
    begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      kind_reg  <= kind_next;
      out_reg   <= out_next;
      rd_reg    <= rd_next;
      ctrl_reg  <= ctrl_next;
      col_reg   <= col_next;
      acyc_reg  <= acyc_next;
      half_reg  <= half_next;
      rej_reg   <= rej_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  wire logic wr_cyc = (st_reg == S_WLOW) || (st_reg == S_WHIGH);
  always_comb
  begin
    pins_o.cle      = wr_cyc && kind_reg == NFC_K_CMD;
    pins_o.ale      = wr_cyc && kind_reg == NFC_K_ADDR;
    pins_o.ce_n     = ~(ctrl_reg[`NFC_CTRL_CE] || !idle);
    pins_o.we_n     = ~(st_reg == S_WLOW);
    pins_o.re_n     = ~(st_reg == S_RLOW);
    pins_o.wg_n     = ctrl_reg[`NFC_CTRL_WG];
    pins_o.lock_sel = ctrl_reg[`NFC_CTRL_LOCK];
    pins_o.io_oe    = wr_cyc;
    pins_o.io_out   = out_reg;
  end
  assign rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wpulse;
    !pins_o.we_n ##1 pins_o.we_n;
  endsequence
  a_latch_excl: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(pins_o.cle && pins_o.ale)) else $error("both latch enables high");
  a_we_sel: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !pins_o.we_n |-> !pins_o.ce_n) else $error("strobe without select");
  a_io_stable: assert property (@(posedge core_clk_i) disable iff (rst_i || !clk_en_i)
    s_wpulse |-> $stable(pins_o.io_out) && pins_o.io_oe) else $error("io moved at strobe");
  a_addr_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pins_o.ale |-> pins_o.io_out[15:8] == 8'h00) else $error("upper lines in address");
  a_cmd_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pins_o.cle |-> pins_o.io_out[15:8] == 8'h00) else $error("upper lines in command");
  a_no_drive_rd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !pins_o.re_n |-> !pins_o.io_oe) else $error("drive during read");
  a_half_x16: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (pins_o.cle && x16) |-> pins_o.io_out[7:0] != `NFC_OP_READ_HI) else $error("01h to x16");
  a_re_len: assert property (@(posedge core_clk_i) disable iff (rst_i || !clk_en_i)
    $fell(pins_o.re_n) |-> !pins_o.re_n [*3] ##1 pins_o.re_n) else $error("read pulse length");
endmodule

// >>> bench/nfc_dev_model.sv
// Purpose: behavioural flash device seen by the host bench
// Assumes: pins from nfc_host; the device has no clock
// Notes:   busy time shortened to 2 us to keep the run short
`timescale 1ns/100ps
module nfc_dev_model (
  input  wire nfc_pkg::nfc_pins_s pins_i,
  output logic             [15:0] io_o = 16'h0F0F,
  output logic                    busy_n_o = 1'b1
);
  import nfc_pkg::*;
  // ------------------------------------------------------------------
  // latches
  // ------------------------------------------------------------------
  logic [7:0]  cmd_reg = 8'hFF;
  logic [7:0]  col_reg = 8'h00;
  logic [15:0] page_reg = 16'h0000;
  logic [1:0]  acnt = 2'h0;
  logic [1:0]  aidx;
  logic        half_sel = 1'b0;
  logic        upper_bad = 1'b0;
  logic        go = 1'b0;
  wire         locked = pins_i.lock_sel && !pins_i.wg_n;

  always @(posedge pins_i.we_n)
  begin
    if (!pins_i.ce_n && pins_i.cle)
    begin
      cmd_reg = pins_i.io_out[7:0];
      acnt = 2'h0;
      if (cmd_reg == 8'h00)
        half_sel = 1'b0;
      if (cmd_reg == 8'h01)
        half_sel = 1'b1;
      if (cmd_reg == 8'hD0 && pins_i.wg_n)
        go = !go;
    end
    else if (!pins_i.ce_n && pins_i.ale)
    begin
      if (pins_i.io_out[15:8] != 8'h00)
        upper_bad = 1'b1;
      aidx = (cmd_reg == 8'h60) ? acnt + 2'h1 : acnt;
      if (aidx == 2'h0)
        col_reg = pins_i.io_out[7:0];
      if (aidx == 2'h1)
        page_reg[7:0] = pins_i.io_out[7:0];
      if (aidx == 2'h2)
        page_reg[15:8] = pins_i.io_out[7:0];
      if (aidx != 2'h3)
        acnt = acnt + 2'h1;
    end
  end

  always @(go)
  begin
    busy_n_o = 1'b0;
    #2000;
    busy_n_o = 1'b1;
  end

  always @(negedge pins_i.re_n)
    if (!pins_i.ce_n)
    begin
      io_o = {8'h5A, col_reg};
      col_reg = col_reg + 8'h01;
    end

  // no pull, released lines show a stale inverse
  always @(posedge pins_i.re_n or posedge pins_i.ce_n)
  begin
    #40;
    io_o = ~io_o;
  end
endmodule

// >>> bench/tb_nfc_host.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: register map of nfc_defines.svh
// Notes:   every wait is bounded
`timescale 1ns/100ps
`include "nfc_defines.svh"
module tb_nfc_host;
  import nfc_pkg::*;
  // ------------------------------------------------------------------
  // harness
  // ------------------------------------------------------------------
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        clk_en = 1'b1;
  nfc_bus_s    bus = '0;
  logic [15:0] rdata;
  nfc_pins_s   pins;
  logic [15:0] io_in;
  logic        busy_n;
  int          mismatches = 0;
  int          check_count = 0;
  logic [15:0] d;
  logic [7:0]  ab [4] = '{8'h12, 8'h34, 8'h56, 8'h78};

  always #25 core_clk_i = ~core_clk_i;

  nfc_host i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .bus_i(bus),
                  .rdata_o(rdata), .pins_o(pins), .io_in_i(io_in), .busy_n_i(busy_n));
  nfc_dev_model i_model (.pins_i(pins), .io_o(io_in), .busy_n_o(busy_n));

  task automatic report_and_stop();
    $display("TB: mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge core_clk_i);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // polls a status bit; running out of polls ends the run
  task automatic waitbit(input int b, input logic v, input int n);
    for (int i = 0; i < n; i++)
    begin
      rd(`NFC_REG_STAT);
      if (d[b] === v)
        return;
    end
    mismatches++;
    $display("CHECK FAILED status bit %0d expected %b seen %b", b, v, d[b]);
    report_and_stop();
  endtask

  task automatic op(input nfc_kind_e k, input logic [7:0] b);
    wr(`NFC_REG_CMD, {6'h00, k, b});
    waitbit(0, 1'b0, 20);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd(`NFC_REG_CTRL);
    chk("ctrl", `NFC_CTRL_RST, d);
    rd(`NFC_REG_STAT);
    chk("stat", 16'h0000, d);
    chk("idle pins", 16'h003C, {8'h00, pins[23:16]});
  endtask

  task automatic t_cmds();
    wr(`NFC_REG_CTRL, 16'h0003);
    op(NFC_K_CMD, `NFC_OP_READ_HI);
    chk("cmd", 16'h0001, {8'h00, i_model.cmd_reg});
    chk("half set", 16'h0001, {15'h0000, i_model.half_sel});
    op(NFC_K_CMD, `NFC_OP_READ_LO);
    chk("half clr", 16'h0000, {15'h0000, i_model.half_sel});
    rd(`NFC_REG_STAT);
    chk("stat half", 16'h0000, {15'h0000, d[5]});
    wr(`NFC_REG_CTRL, 16'h000B);
    op(NFC_K_CMD, `NFC_OP_READ_HI);
    rd(`NFC_REG_STAT);
    chk("rejected", 16'h0001, {15'h0000, d[4]});
    chk("cmd kept", 16'h0000, {8'h00, i_model.cmd_reg});
  endtask

  task automatic t_addr();
    for (int i = 0; i < 4; i++)
      op(NFC_K_ADDR, ab[i]);
    chk("column", 16'h0012, {8'h00, i_model.col_reg});
    chk("page", 16'h5634, i_model.page_reg);
    chk("upper lines", 16'h0000, {15'h0000, i_model.upper_bad});
    rd(`NFC_REG_STAT);
    chk("addr count", 16'h0003, {14'h0000, d[3:2]});
  endtask

  task automatic t_read();
    wr(`NFC_REG_COL, 16'h0012);
    for (int i = 0; i < 2; i++)
    begin
      op(NFC_K_RDATA, 8'h00);
      rd(`NFC_REG_DATA);
      chk("word", {8'h5A, 8'h12 + 8'(i)}, d);
    end
    rd(`NFC_REG_COL);
    chk("col count", 16'h0014, d);
  endtask

  task automatic t_erase();
    wr(`NFC_REG_CTRL, 16'h0003);
    op(NFC_K_CMD, `NFC_OP_ERASE);
    op(NFC_K_ADDR, 8'hAA);
    op(NFC_K_ADDR, 8'hBB);
    op(NFC_K_CMD, 8'hD0);
    chk("erase page", 16'hBBAA, i_model.page_reg);
    waitbit(1, 1'b1, 10);
    wr(`NFC_REG_CTRL, 16'h0002);
    rd(`NFC_REG_STAT);
    chk("busy deselected", 16'h0001, {15'h0000, d[1]});
    waitbit(1, 1'b0, 60);
    wr(`NFC_REG_CTRL, 16'h0001);
    op(NFC_K_CMD, `NFC_OP_ERASE);
    op(NFC_K_CMD, 8'hD0);
    repeat (3)
    begin
      rd(`NFC_REG_STAT);
      chk("guarded busy", 16'h0000, {15'h0000, d[1]});
    end
    wr(`NFC_REG_CTRL, 16'h0005);
    #1 chk("locked", 16'h0001, {15'h0000, i_model.locked});
    wr(`NFC_REG_CTRL, 16'h0007);
    #1 chk("unlocked", 16'h0000, {15'h0000, i_model.locked});
    wr(`NFC_REG_CTRL, 16'h0001);
    #1 chk("lock off", 16'h0000, {15'h0000, i_model.locked});
  endtask

  // writes while the clock enable is low must leave all state alone
  task automatic t_freeze();
    @(posedge core_clk_i);
    clk_en <= 1'b0;
    wr(`NFC_REG_CTRL, 16'h0000);
    clk_en <= 1'b1;
    rd(`NFC_REG_CTRL);
    chk("frozen ctrl", 16'h0001, d);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_cmds();
    t_addr();
    t_read();
    t_erase();
    t_freeze();
    report_and_stop();
  end
endmodule
